// ===== rtl/tec_timer.sv
// The APB interface to the registers and the placing of the registers were decided locally.
`default_nettype none
module tec_timer
  import tec_pkg::*;
#(
  parameter int PSC_STAGES = 8
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_ext_count_pin,
  output logic             o_timer_irq,
  output logic             o_wakeup,
  output logic             o_overflow
);
  // ****************************************
  // state
  // ****************************************
  logic [7:0] counter;
  logic [7:0] preload;
  logic [2:0] prescale_select;
  logic       edge_select_bit;
  logic       run_bit;
  logic [1:0] mode_sel;
  logic       timer_irq_enable;
  logic       power_down;
  logic       ovf_sticky;
  logic       pin_s1;
  logic       pin_s2;
  logic       pin_d;
  logic [PSC_STAGES-1:0] psc;
  logic [PSC_STAGES-1:0] psc_d;
  logic       next_tick;
  logic       pin_rise;
  logic       pin_fall;
  logic       active_edge;
  logic       width_end;
  logic       access;
  logic       wr_en;
  logic       do_count;
  logic       ovf;
  logic       setup;
  logic       sel_count;
  logic       sel_ctrl;
  logic       sel_interrupt_control;
  logic       sel_stat;
  logic       sel_known;
  logic       cnt_wr;
  logic       ctl_wr;
  logic       interrupt_control_wr;
  logic       stat_wr;
  logic [31:0] next_prdata;
  logic [PSC_STAGES-1:0] stage_fall;

  // ****************************************
  // address decode
  // ****************************************
  // one word per register, exact byte address match
  function automatic logic reg_hit(input logic [11:0] addr,
                                   input logic [11:0] off);
    return addr == off;
  endfunction

  // apb phases, zero wait states
  assign access = i_psel && i_penable;
  assign wr_en  = access && i_pwrite;
  assign setup  = i_psel && !i_penable;

  // ****************************************
  // register selects
  // ****************************************
  // shared by write strobes and read mux
  assign sel_count = reg_hit(i_paddr, TEC_OFF_COUNT);
  assign sel_ctrl  = reg_hit(i_paddr, TEC_OFF_CTRL);
  assign sel_interrupt_control  = reg_hit(i_paddr, TEC_OFF_INTERRUPT_CONTROL);
  assign sel_stat  = reg_hit(i_paddr, TEC_OFF_STAT);
  assign sel_known = sel_count || sel_ctrl || sel_interrupt_control || sel_stat;

  // ****************************************
  // write strobes
  // ****************************************
  // one strobe per register, at the access edge
  assign cnt_wr  = wr_en && sel_count;
  assign ctl_wr  = wr_en && sel_ctrl;
  assign interrupt_control_wr = wr_en && sel_interrupt_control;
  assign stat_wr = wr_en && sel_stat;

  // ****************************************
  // pin synchroniser and edges
  // ****************************************
  // two flops then edge history
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1 <= 1'b1;                                // idle level, no false edge
      pin_s2 <= 1'b1;
      pin_d  <= 1'b1;
    end else if (i_ce) begin
      pin_s1 <= i_ext_count_pin;
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
    end
  end

  assign pin_rise = pin_s2 && !pin_d;
  assign pin_fall = !pin_s2 && pin_d;
  // edge bit low: rising; high: falling
  assign active_edge = edge_select_bit ? pin_fall : pin_rise;
  // width mode ends when pin returns to original level
  assign width_end = (mode_sel == TEC_MODE_WIDTH) && run_bit
                     && (edge_select_bit ? pin_fall : pin_rise);

  // ****************************************
  // prescaler
  // ****************************************
  // free-running divider on system clock
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      psc   <= '0;
      psc_d <= '0;
    end else if (i_ce) begin
      psc   <= psc + 1'b1;
      psc_d <= psc;
    end
  end

  // falling edge of each prescaler stage
  for (genvar g = 0; g < PSC_STAGES; g++) begin : g_stage
    assign stage_fall[g] = psc_d[g] && !psc[g];
  end

  // tick from the selected stage
  always_comb begin
    next_tick = stage_fall[prescale_select];
  end

  // ****************************************
  // count enable
  // ****************************************
  always_comb begin
    do_count = 1'b0;
    unique case (mode_sel)
      TEC_MODE_TIMER: do_count = next_tick && !power_down;
      TEC_MODE_EVENT: do_count = active_edge;
      TEC_MODE_WIDTH: do_count = next_tick && !power_down
                                 && (edge_select_bit ? pin_s2 : !pin_s2);
      default:        do_count = 1'b0;               // mode off
    endcase
    // run bit gates; access inhibits the count
    do_count = do_count && run_bit && !access;
  end

  // ****************************************
  // overflow
  // ****************************************
  assign ovf = do_count && (counter == 8'hFF);

  // ****************************************
  // counter and preload
  // ****************************************
  // preload written by software
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      preload <= TEC_PRELOAD_RESET;
    end else if (i_ce && cnt_wr) begin
      preload <= i_pwdata[7:0];
    end
  end

  // count, reload on overflow
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      counter <= TEC_PRELOAD_RESET;
    end else if (i_ce) begin
      if (cnt_wr && !run_bit) begin
        counter <= i_pwdata[7:0];
      end else if (ovf) begin
        counter <= preload;
      end else if (do_count) begin
        counter <= counter + 8'h01;
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  // prescaler ratio
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prescale_select <= TEC_CTRL_RESET[2:0];
    end else if (i_ce && ctl_wr) begin
      prescale_select <= i_pwdata[TEC_CTRL_PSC_LSB +: 3];
    end
  end

  // active pin polarity
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      edge_select_bit <= TEC_CTRL_RESET[TEC_CTRL_EDGE];
    end else if (i_ce && ctl_wr) begin
      edge_select_bit <= i_pwdata[TEC_CTRL_EDGE];
    end
  end

  // mode select pair
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_sel <= TEC_CTRL_RESET[7:6];
    end else if (i_ce && ctl_wr) begin
      mode_sel <= {i_pwdata[TEC_CTRL_MODE_HI], i_pwdata[TEC_CTRL_MODE_LO]};
    end
  end

  // run bit; self clear at end of pulse
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_bit <= 1'b0;
    end else if (i_ce) begin
      if (ctl_wr) begin
        run_bit <= i_pwdata[TEC_CTRL_RUN];
      end else if (width_end) begin
        run_bit <= 1'b0;
      end
    end
  end

  // timer interrupt enable
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      timer_irq_enable <= 1'b0;
    end else if (i_ce && interrupt_control_wr) begin
      timer_irq_enable <= i_pwdata[TEC_INTERRUPT_CONTROL_TIE];
    end
  end

  // power-down, overflow wakes and wins over a set
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      power_down <= 1'b0;
    end else if (i_ce) begin
      if (interrupt_control_wr) begin
        power_down <= i_pwdata[TEC_INTERRUPT_CONTROL_PD] && !ovf;
      end else if (ovf) begin
        power_down <= 1'b0;
      end
    end
  end

  // sticky overflow, set wins over write-one clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ovf_sticky <= 1'b0;
    end else if (i_ce) begin
      if (ovf) begin
        ovf_sticky <= 1'b1;
      end else if (stat_wr && i_pwdata[0]) begin
        ovf_sticky <= 1'b0;
      end
    end
  end

  // ****************************************
  // event outputs
  // ****************************************
  // overflow pulse
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_overflow <= 1'b0;
    end else if (i_ce) begin
      o_overflow <= ovf;
    end
  end

  // interrupt only when enabled
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_timer_irq <= 1'b0;
    end else if (i_ce) begin
      o_timer_irq <= ovf && timer_irq_enable;
    end
  end

  // wake-up only from power-down
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wakeup <= 1'b0;
    end else if (i_ce) begin
      o_wakeup <= ovf && power_down;
    end
  end

  // ****************************************
  // apb read side
  // ****************************************
  // ready one cycle after setup, zero wait states
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
    end else if (i_ce) begin
      o_pready <= setup;
    end
  end

  // error with ready on an unmapped address
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pslverr <= 1'b0;
    end else if (i_ce) begin
      o_pslverr <= setup && !sel_known;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  // read mux, unmapped words read zero
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (sel_count) begin
      next_prdata = {24'h00_0000, counter};
    end else if (sel_ctrl) begin
      next_prdata = {24'h00_0000, mode_sel, 1'b0, run_bit,
                     edge_select_bit, prescale_select};
    end else if (sel_interrupt_control) begin
      next_prdata = {30'h0000_0000, power_down, timer_irq_enable};
    end else if (sel_stat) begin
      next_prdata = {31'h0000_0000, ovf_sticky};
    end
  end

  // latched at setup of reads and of unmapped writes
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= '0;
    end else if (i_ce && setup && (!i_pwrite || !sel_known)) begin
      o_prdata <= next_prdata;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/tec_pkg.sv
`default_nettype none
package tec_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] TEC_OFF_COUNT = 12'h000;
  localparam logic [11:0] TEC_OFF_CTRL  = 12'h004;
  localparam logic [11:0] TEC_OFF_INTERRUPT_CONTROL  = 12'h008;
  localparam logic [11:0] TEC_OFF_STAT  = 12'h00C;
  // ****************************************
  // field positions
  // ****************************************
  localparam int TEC_CTRL_PSC_LSB = 0;
  localparam int TEC_CTRL_EDGE    = 3;
  localparam int TEC_CTRL_RUN     = 4;
  localparam int TEC_CTRL_MODE_LO = 6;
  localparam int TEC_CTRL_MODE_HI = 7;
  localparam int TEC_INTERRUPT_CONTROL_TIE     = 0;
  localparam int TEC_INTERRUPT_CONTROL_PD      = 1;
  // ****************************************
  // reset values and mode encodings
  // ****************************************
  localparam logic [7:0] TEC_CTRL_RESET = 8'h00;
  localparam logic [7:0] TEC_PRELOAD_RESET = 8'h00;
  localparam logic [1:0] TEC_MODE_TIMER = 2'b10;
  localparam logic [1:0] TEC_MODE_EVENT = 2'b01;
  localparam logic [1:0] TEC_MODE_WIDTH = 2'b11;
endpackage
`default_nettype wire

// ===== tb/tec_timer_sva.sv
`default_nettype none
module tec_timer_sva (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_ce,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_timer_irq,
  input wire logic        o_wakeup,
  input wire logic        o_overflow
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ****************************************
  // bus and event checks
  // ****************************************
  AST_RDY_SETUP: assert property (i_ce && i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  AST_RDY_PULSE: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  AST_RDY_ACCESS: assert property (o_pready |-> i_psel && i_penable)
    else $error("ready outside access");
  AST_ERR_RDY: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  AST_ERR_ZERO: assert property (o_pslverr |-> o_prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_OVF_PULSE: assert property (o_overflow |=> !o_overflow)
    else $error("overflow pulse too long");
  AST_IRQ_OVF: assert property (o_timer_irq |-> o_overflow)
    else $error("irq without overflow");
  AST_WAKE_OVF: assert property (o_wakeup |-> o_overflow)
    else $error("wakeup without overflow");
  // main scenarios reached
  cover property (o_overflow && o_timer_irq);
  cover property (o_wakeup);
  cover property (o_pready && o_pslverr);
endmodule
bind tec_timer tec_timer_sva sva_u (.i_clk, .i_rst_n, .i_ce, .i_psel,
  .i_penable, .o_prdata, .o_pready, .o_pslverr, .o_timer_irq, .o_wakeup,
  .o_overflow);
`default_nettype wire

// ===== tb/tec_pin_src.sv
`default_nettype none
module tec_pin_src (
  input  wire logic i_clk,
  output var logic  o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // pin idles high, as with its pull-high
  initial o_pin = 1'b1;
  // move to a level and let it settle through the synchroniser
  task automatic level(input logic v);
    @(posedge i_clk);
    o_pin <= v;
    repeat (6) @(posedge i_clk);
  endtask
  // n low pulses, lo cycles low, hi cycles high
  task automatic pulse(input int n, input int lo, input int hi);
    repeat (n) begin
      @(posedge i_clk);
      o_pin <= 1'b0;
      repeat (lo) @(posedge i_clk);
      o_pin <= 1'b1;
      repeat (hi) @(posedge i_clk);
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_tec_timer.sv
`default_nettype none
module tb_tec_timer import tec_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
  logic i_pwrite = 1'b0, o_pready, o_pslverr, o_timer_irq, o_wakeup;
  logic o_overflow, pin, err;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000, o_prdata, rd, v;
  int error_cnt = 0, n_compared = 0, cyc = 0, n_ovf = 0, n_irq = 0;
  int n_wake = 0, e;
  tec_timer dut_u (.i_clk, .i_rst_n, .i_ce(1'b1), .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .i_ext_count_pin(pin), .o_timer_irq, .o_wakeup, .o_overflow);
  tec_pin_src pin_u (.i_clk, .o_pin(pin));
  always #4 i_clk = ~i_clk;
  // event counters and hang limit
  always @(posedge i_clk) begin
    cyc++;
    if (o_overflow === 1'b1) n_ovf++;
    if (o_timer_irq === 1'b1) n_irq++;
    if (o_wakeup === 1'b1) n_wake++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until ready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, x);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rdc(TEC_OFF_CTRL, 32'h0000_0000);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    $display("test regs done");
    wr(TEC_OFF_CTRL, 32'h0000_0040); // event mode, pin as input
    wr(TEC_OFF_COUNT, 32'h0000_0000);
    wr(TEC_OFF_CTRL, 32'h0000_0050);
    pin_u.level(1'b0);
    rdc(TEC_OFF_COUNT, 32'h0000_0000);
    pin_u.level(1'b1);
    rdc(TEC_OFF_COUNT, 32'h0000_0001);
    wr(TEC_OFF_CTRL, 32'h0000_0058);
    pin_u.level(1'b0);
    rdc(TEC_OFF_COUNT, 32'h0000_0002);
    pin_u.level(1'b1);
    rdc(TEC_OFF_COUNT, 32'h0000_0002);
    $display("test edges done");
    wr(TEC_OFF_CTRL, 32'h0000_0048);
    wr(TEC_OFF_COUNT, 32'h0000_00FE);
    rdc(TEC_OFF_COUNT, 32'h0000_00FE);
    wr(TEC_OFF_INTERRUPT_CONTROL, 32'h0000_0001);
    wr(TEC_OFF_CTRL, 32'h0000_0058);
    pin_u.pulse(1, 4, 6);
    wr(TEC_OFF_COUNT, 32'h0000_0020);
    rdc(TEC_OFF_COUNT, 32'h0000_00FF);
    pin_u.pulse(1, 4, 6);
    rdc(TEC_OFF_COUNT, 32'h0000_0020);
    chk(n_ovf + n_irq * 4 + n_wake * 16, 5);
    wr(TEC_OFF_CTRL, 32'h0000_0048);
    wr(TEC_OFF_COUNT, 32'h0000_00FF);
    wr(TEC_OFF_INTERRUPT_CONTROL, 32'h0000_0002);
    wr(TEC_OFF_CTRL, 32'h0000_0058);
    pin_u.pulse(1, 4, 6);
    rdc(TEC_OFF_COUNT, 32'h0000_00FF);
    chk(n_ovf + n_irq * 4 + n_wake * 16, 22);
    $display("test overflow done");
    for (int p = 0; p < 3; p += 2) begin
      wr(TEC_OFF_CTRL, 32'h0000_0080 | p);
      wr(TEC_OFF_COUNT, 32'h0000_0000);
      wr(TEC_OFF_CTRL, 32'h0000_0090 | p);
      repeat (64) @(posedge i_clk);
      wr(TEC_OFF_CTRL, 32'h0000_0080 | p);
      apb(1'b0, TEC_OFF_COUNT, 32'h0000_0000);
      e = 67 >> (p + 1);
      v = rd;
      chk(rd[7:0] inside {[e - 3:e + 3]}, 1);
      repeat (20) @(posedge i_clk);
      rdc(TEC_OFF_COUNT, v);
    end
    $display("test timer done");
    wr(TEC_OFF_CTRL, 32'h0000_00C0);
    wr(TEC_OFF_COUNT, 32'h0000_0000);
    wr(TEC_OFF_CTRL, 32'h0000_00D0);
    pin_u.pulse(1, 40, 8);
    apb(1'b0, TEC_OFF_COUNT, 32'h0000_0000);
    v = rd;
    chk(rd[7:0] inside {[17:23]}, 1);
    rdc(TEC_OFF_CTRL, 32'h0000_00C0);
    pin_u.pulse(1, 40, 8);
    rdc(TEC_OFF_COUNT, v);
    $display("test width done");
    report_and_stop();
  end
endmodule
`default_nettype wire
